// >>> core/regen_cursor_pkg.sv
// Overview of operation
// - after both searches, fetch first byte; examine pulse tests cursor bit and key activity.
// - cursor bit set with pending key activity enters cursor adjustment instead.
// - otherwise check start marker, then dispatch on latched mode.
// - graphic, count 0: stage first byte, step and fetch next byte.
// - bytes two and three go by count 1 and 2; fetch fourth; count reaches 3.
// - with four bytes held, wait 135 ns, clear count, sample interlock and pen.
// - both clear: pulse moves X and Y to deflection outputs.
// - unprotected character mode with jump request inserts cursor at address just read.
// - else wait for interlock and pen clear, then hand over byte, cursor, new line.
// - character with cursor bit is drawn with cursor beneath it.
// - cursor in protected area displayed, but keyboard character entry refused.
// - jump places cursor at first address of next unprotected area.
// - unprotected: key character replaces code at cursor, cursor then advances.
// - address counter steps one per buffer cycle unless adjustment blocks it.
// - during adjustment stepping and display inhibited; afterwards both resume.
// - cursor bit with advance: block stepping, counter minus one.
// - next cycle rereads, clears cursor bit, flips parity, writes, counter plus one.
// - cursor handling only in character mode with all three features present.
// - advance: next address gets cursor bit, parity flip, counter minus one.
// - backspace: after clearing, counter down, preceding address gets cursor, then up.
// - jump removal sets jump protect for this mode and holds jump request.
package regen_cursor_pkg;

  localparam int ADDR_W = 12;
  localparam int CODE_W = 8;
  localparam int WORD_W = 10;
  localparam int CURSOR_BIT = 8;
  localparam int PARITY_BIT = 9;
  localparam int KEY_W = 6;

  localparam logic [CODE_W-1:0] START_MARKER_CODE = 8'h2a;
  // new line value is a plain default, override per character set
  localparam logic [CODE_W-1:0] NEW_LINE_CODE = 8'h15;

  localparam int DEFL_DELAY_NS = 135;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [2:0] DEFL_DELAY_CYCLES =
    3'((DEFL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [7:0] REG_FEATURE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDRESS = 8'h08;
  localparam logic [2:0] FEATURE_RESET = 3'h7;
  localparam int FEAT_CHARGEN = 0;
  localparam int FEAT_KEYBOARD = 1;
  localparam int FEAT_BUFFER = 2;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_READ      = 3'h1,
    ST_LATCH     = 3'h3,
    ST_STORE     = 3'h2,
    ST_EXAMINE   = 3'h6,
    ST_CHAR_WAIT = 3'h7,
    ST_DELAY     = 3'h5,
    ST_DEFL_WAIT = 3'h4
  } state_t;

  typedef enum logic [1:0] {
    ACT_NONE    = 2'h0,
    ACT_REMOVE  = 2'h1,
    ACT_INSERT  = 2'h2,
    ACT_REPLACE = 2'h3
  } act_t;

  typedef enum logic [1:0] {
    KEY_ADV  = 2'h0,
    KEY_BACK = 2'h1,
    KEY_JUMP = 2'h2,
    KEY_CHAR = 2'h3
  } key_kind_t;

endpackage

// >>> core/display_regen_cursor_control.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module display_regen_cursor_control (
  input  wire logic                                 clk_sys,
  input  wire logic                                 arst_n,
  input  wire logic [7:0]                           reg_addr,
  input  wire logic [31:0]                          reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [31:0]                          reg_rdata,
  input  wire logic                                 searches_done,
  input  wire logic [regen_cursor_pkg::ADDR_W-1:0]  first_data_addr,
  input  wire logic                                 mode_graphic,
  input  wire logic                                 mode_char,
  input  wire logic                                 mode_protected,
  input  wire logic                                 deflection_interlock,
  input  wire logic                                 pen_hit_latch,
  input  wire logic                                 key_advance,
  input  wire logic                                 key_backspace,
  input  wire logic                                 key_jump,
  input  wire logic                                 key_char_strobe,
  input  wire logic [regen_cursor_pkg::KEY_W-1:0]   key_char,
  output logic      [regen_cursor_pkg::ADDR_W-1:0]  mem_addr,
  output logic                                      mem_rd,
  output logic                                      mem_wr,
  output logic      [regen_cursor_pkg::WORD_W-1:0]  mem_wdata,
  input  wire logic [regen_cursor_pkg::WORD_W-1:0]  mem_rdata,
  output logic                                      byte_examine_pulse,
  output logic                                      buffer_cycle_start_pulse,
  output logic                                      start_marker_found,
  output logic                                      deflection_transfer_pulse,
  output logic      [15:0]                          defl_x,
  output logic      [15:0]                          defl_y,
  output logic                                      char_strobe,
  output logic      [regen_cursor_pkg::CODE_W-1:0]  char_code,
  output logic                                      char_cursor,
  output logic                                      char_new_line
);
  import regen_cursor_pkg::*;

  typedef struct packed {
    state_t              state;
    act_t                act;
    key_kind_t           adj_kind;
    logic                then_examine;
    logic [ADDR_W-1:0]   bac;
    logic [ADDR_W-1:0]   byte_addr;
    logic [WORD_W-1:0]   byte_reg;
    logic [1:0]          byte_count;
    logic [2:0]          delay;
    logic [CODE_W-1:0]   x_hi;
    logic [CODE_W-1:0]   x_lo;
    logic [CODE_W-1:0]   y_hi;
    logic                graphic;
    logic                character;
    logic                protect_mode;
    logic                jump_protect;
    logic                jump_request;
    logic                pend;
    key_kind_t           pend_kind;
    logic [KEY_W-1:0]    pend_char;
    logic [2:0]          feature;
    logic [31:0]         rdata;
    logic                sm_pulse;
    logic                defl_pulse;
    logic [15:0]         x_out;
    logic [15:0]         y_out;
    logic                ch_pulse;
    logic [CODE_W-1:0]   ch_code;
    logic                ch_cursor;
    logic                ch_nl;
  } state_s_t;

  state_s_t s;
  state_s_t next_s;

  logic cursor_en;
  logic cur_bit;
  logic key_any;
  logic pend_done;

  assign cursor_en = s.character & (&s.feature);
  assign cur_bit   = s.byte_reg[CURSOR_BIT];
  assign key_any   = key_advance | key_backspace | key_jump | key_char_strobe;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    logic [WORD_W-1:0] w;
    w = mem_rdata;
    next_s = s;
    pend_done = 1'b0;
    next_s.sm_pulse = 1'b0;
    next_s.defl_pulse = 1'b0;
    next_s.ch_pulse = 1'b0;

    case (s.state)
      ST_IDLE: begin
        if (searches_done && s.feature[FEAT_BUFFER]) begin
          next_s.bac = first_data_addr;
          next_s.graphic = mode_graphic;
          next_s.character = mode_char;
          next_s.protect_mode = mode_protected;
          next_s.jump_protect = mode_protected;
          next_s.byte_count = 2'h0;
          next_s.act = ACT_NONE;
          next_s.state = ST_READ;
        end
      end
      ST_READ: begin
        if (s.act == ACT_NONE) begin
          next_s.bac = s.bac + 1'b1;
        end
        next_s.state = ST_LATCH;
      end
      ST_LATCH: begin
        next_s.state = ST_STORE;
        next_s.then_examine = 1'b1;
        next_s.act = ACT_NONE;
        case (s.act)
          ACT_REMOVE: begin
            w[CURSOR_BIT] = 1'b0;
            w[PARITY_BIT] = ~mem_rdata[PARITY_BIT];
            case (s.adj_kind)
              KEY_BACK: begin
                next_s.bac = s.bac - 1'b1;
                next_s.act = ACT_INSERT;
                next_s.then_examine = 1'b0;
              end
              KEY_JUMP: begin
                next_s.bac = s.bac + 1'b1;
                next_s.jump_protect = 1'b1;
                next_s.jump_request = 1'b1;
                pend_done = 1'b1;
              end
              default: begin
                next_s.bac = s.bac + 1'b1;
                next_s.act = ACT_INSERT;
                next_s.then_examine = 1'b0;
              end
            endcase
          end
          ACT_REPLACE: begin
            w = {1'b0, 1'b0, {(CODE_W-KEY_W){1'b0}}, s.pend_char};
            w[PARITY_BIT] = ~^w[CURSOR_BIT:0];
            next_s.bac = s.bac + 1'b1;
            next_s.act = ACT_INSERT;
            next_s.adj_kind = KEY_ADV;
            next_s.then_examine = 1'b0;
          end
          ACT_INSERT: begin
            w[CURSOR_BIT] = 1'b1;
            w[PARITY_BIT] = ~mem_rdata[PARITY_BIT];
            case (s.adj_kind)
              KEY_BACK: begin
                next_s.bac = s.bac + 1'b1;
                next_s.then_examine = 1'b0;
                pend_done = 1'b1;
              end
              KEY_JUMP: begin
                next_s.bac = s.bac + 1'b1;
                next_s.jump_request = 1'b0;
              end
              default: begin
                next_s.bac = s.bac - 1'b1;
                next_s.then_examine = 1'b0;
                pend_done = 1'b1;
              end
            endcase
          end
          default: begin
          end
        endcase
        next_s.byte_reg = w;
      end
      ST_STORE: begin
        // the write-back has gone out; the byte register keeps its copy
        next_s.state = s.then_examine ? ST_EXAMINE : ST_READ;
      end
      ST_EXAMINE: begin
        next_s.state = ST_READ;
        if (cursor_en && cur_bit && s.pend) begin
          if (s.pend_kind == KEY_CHAR && s.protect_mode) begin
            pend_done = 1'b1;
            next_s.state = ST_CHAR_WAIT;
          end else begin
            next_s.bac = s.bac - 1'b1;
            next_s.adj_kind = s.pend_kind;
            next_s.act = (s.pend_kind == KEY_CHAR) ? ACT_REPLACE : ACT_REMOVE;
          end
        end else if (s.byte_reg[CODE_W-1:0] == START_MARKER_CODE
                     && !s.byte_addr[0]) begin
          next_s.sm_pulse = 1'b1;
          next_s.state = ST_IDLE;
        end else if (s.graphic) begin
          case (s.byte_count)
            2'h0: next_s.x_hi = s.byte_reg[CODE_W-1:0];
            2'h1: next_s.x_lo = s.byte_reg[CODE_W-1:0];
            2'h2: next_s.y_hi = s.byte_reg[CODE_W-1:0];
            default: begin
            end
          endcase
          if (s.byte_count == 2'h3) begin
            next_s.delay = DEFL_DELAY_CYCLES - 3'h1;
            next_s.state = ST_DELAY;
          end else begin
            next_s.byte_count = s.byte_count + 2'h1;
          end
        end else if (s.character) begin
          if (cursor_en && !s.jump_protect && s.jump_request) begin
            next_s.bac = s.bac - 1'b1;
            next_s.adj_kind = KEY_JUMP;
            next_s.act = ACT_INSERT;
          end else begin
            next_s.state = ST_CHAR_WAIT;
          end
        end
      end
      ST_CHAR_WAIT: begin
        if (!deflection_interlock && !pen_hit_latch) begin
          next_s.ch_pulse = 1'b1;
          next_s.ch_code = s.byte_reg[CODE_W-1:0];
          next_s.ch_cursor = cur_bit & s.feature[FEAT_CHARGEN];
          next_s.ch_nl = s.byte_reg[CODE_W-1:0] == NEW_LINE_CODE;
          next_s.state = ST_READ;
        end
      end
      ST_DELAY: begin
        if (s.delay == 3'h0) begin
          next_s.byte_count = 2'h0;
          next_s.state = ST_DEFL_WAIT;
        end else begin
          next_s.delay = s.delay - 3'h1;
        end
      end
      ST_DEFL_WAIT: begin
        if (!deflection_interlock && !pen_hit_latch) begin
          next_s.defl_pulse = 1'b1;
          next_s.x_out = {s.x_hi, s.x_lo};
          next_s.y_out = {s.y_hi, s.byte_reg[CODE_W-1:0]};
          next_s.state = ST_READ;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase

    // address taken on entry, so the read cycle already shows it on the bus
    if (next_s.state == ST_READ) begin
      next_s.byte_addr = next_s.bac;
    end

    // a key landing in the cycle that retires the old one is kept
    if (pend_done) begin
      next_s.pend = 1'b0;
    end
    if (key_any && (!s.pend || pend_done)) begin
      next_s.pend = 1'b1;
      next_s.pend_char = key_char;
      if (key_advance) begin
        next_s.pend_kind = KEY_ADV;
      end else if (key_backspace) begin
        next_s.pend_kind = KEY_BACK;
      end else if (key_jump) begin
        next_s.pend_kind = KEY_JUMP;
      end else begin
        next_s.pend_kind = KEY_CHAR;
      end
    end

    // ************************************************************
    // register port
    // ************************************************************
    if (reg_wr && reg_addr == REG_FEATURE) begin
      next_s.feature = reg_wdata[2:0];
    end
    next_s.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        REG_FEATURE: next_s.rdata = {29'h0, s.feature};
        REG_STATUS:  next_s.rdata = {18'h0, s.byte_count, s.pend_kind, s.pend,
                                     s.jump_request, s.jump_protect, s.act, 2'h0, s.state};
        REG_ADDRESS: next_s.rdata = {20'h0, s.bac};
        default:     next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.feature <= FEATURE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata = s.rdata;
  assign mem_addr = s.byte_addr;
  assign mem_rd = s.state == ST_READ;
  assign mem_wr = s.state == ST_STORE;
  assign mem_wdata = s.byte_reg;
  assign byte_examine_pulse = s.state == ST_EXAMINE;
  assign buffer_cycle_start_pulse = s.state == ST_READ;
  assign start_marker_found = s.sm_pulse;
  assign deflection_transfer_pulse = s.defl_pulse;
  assign defl_x = s.x_out;
  assign defl_y = s.y_out;
  assign char_strobe = s.ch_pulse;
  assign char_code = s.ch_code;
  assign char_cursor = s.ch_cursor;
  assign char_new_line = s.ch_nl;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_cursor_branch: assert property (s.state == ST_EXAMINE && cursor_en && cur_bit && s.pend
      && !(s.pend_kind == KEY_CHAR && s.protect_mode)
      |=> s.state == ST_READ && s.act != ACT_NONE && s.bac == $past(s.bac) - 1'b1)
    else $error("cursor adjustment not entered");
  a_normal_step: assert property (s.state == ST_READ && s.act == ACT_NONE
      |=> s.bac == $past(s.bac) + 1'b1)
    else $error("address counter did not step");
  a_remove_write: assert property (s.state == ST_LATCH && s.act == ACT_REMOVE
      |=> !s.byte_reg[CURSOR_BIT] && s.byte_reg[PARITY_BIT] != $past(mem_rdata[PARITY_BIT])
      && s.state == ST_STORE && mem_wr)
    else $error("cursor removal write wrong");
  a_adv_insert: assert property (s.state == ST_LATCH && s.act == ACT_INSERT
      && s.adj_kind == KEY_ADV |=> s.byte_reg[CURSOR_BIT] && s.bac == $past(s.bac) - 1'b1
      ##1 s.state == ST_READ)
    else $error("advance insertion wrong");
  a_back_down: assert property (s.state == ST_LATCH && s.act == ACT_REMOVE
      && s.adj_kind == KEY_BACK |=> s.bac == $past(s.bac) - 1'b1 && s.act == ACT_INSERT)
    else $error("backspace did not step down");
  a_defl_delay: assert property (s.state == ST_EXAMINE && s.graphic && s.byte_count == 2'h3
      && !(cursor_en && cur_bit && s.pend) && !(s.byte_reg[CODE_W-1:0] == START_MARKER_CODE
      && !s.byte_addr[0]) |=> s.state == ST_DELAY [*6] ##1 s.state == ST_DEFL_WAIT
      && s.byte_count == 2'h0)
    else $error("deflection delay wrong");
  a_defl_clear: assert property (deflection_transfer_pulse
      |-> $past(!deflection_interlock && !pen_hit_latch))
    else $error("transfer while interlocked");
  a_jump_latches: assert property (s.state == ST_LATCH && s.act == ACT_REMOVE
      && s.adj_kind == KEY_JUMP |=> s.jump_protect && s.jump_request)
    else $error("jump latches not set");
  a_mode_gate: assert property (s.state == ST_EXAMINE && !cursor_en && s.graphic
      |=> s.act == ACT_NONE)
    else $error("cursor handled outside character mode");
  a_key_retired: assert property (s.state == ST_LATCH && s.act == ACT_INSERT
      && s.adj_kind == KEY_BACK && !key_any |=> !s.pend)
    else $error("key activity not cleared");
  a_protect_entry: assert property (s.state == ST_EXAMINE && cursor_en && cur_bit && s.pend
      && s.pend_kind == KEY_CHAR && s.protect_mode |=> s.act == ACT_NONE
      && s.state == ST_CHAR_WAIT)
    else $error("entry accepted in protected area");
  a_marker_seen: assert property (start_marker_found
      |-> $past(s.byte_reg[CODE_W-1:0] == START_MARKER_CODE && !s.byte_addr[0]))
    else $error("start marker reported without marker byte");
  a_key_replace: assert property (s.state == ST_LATCH && s.act == ACT_REPLACE
      |=> s.byte_reg[CODE_W-1:0] == {2'b00, $past(s.pend_char)}
      && !s.byte_reg[CURSOR_BIT])
    else $error("key character not written");

  c_advance: cover property (s.state == ST_LATCH && s.act == ACT_INSERT && s.adj_kind == KEY_ADV);
  c_deflect: cover property (deflection_transfer_pulse);
  c_char_cursor: cover property (char_strobe && char_cursor);
  c_jump_insert: cover property (s.state == ST_LATCH && s.act == ACT_INSERT
      && s.adj_kind == KEY_JUMP);
  c_replace: cover property (s.state == ST_LATCH && s.act == ACT_REPLACE);

endmodule

// >>> sim/regen_buffer_model.sv
`timescale 1ns/10ps
// ****************************************
// refresh buffer memory behind the block
// ****************************************
module regen_buffer_model (
  input  wire logic                                clk_sys,
  input  wire logic [regen_cursor_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                                mem_rd,
  input  wire logic                                mem_wr,
  input  wire logic [regen_cursor_pkg::WORD_W-1:0] mem_wdata,
  output logic      [regen_cursor_pkg::WORD_W-1:0] mem_rdata
);
  import regen_cursor_pkg::*;
  logic [WORD_W-1:0] words [0:(1<<ADDR_W)-1];

  initial begin
    mem_rdata = 10'h155;
  end

  // data stand in the cycle after the read; then the lines toggle every cycle
  // so a sample one cycle late never passes for the stored word
  always @(posedge clk_sys) begin
    if (mem_wr === 1'b1) begin
      words[mem_addr] <= mem_wdata;
    end
    if (mem_rd === 1'b1) begin
      mem_rdata <= words[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// >>> sim/display_regen_cursor_control_tb_top.sv
`timescale 1ns/10ps
module display_regen_cursor_control_tb_top;
  import regen_cursor_pkg::*;
  // ****************************************
  // signals and reference state
  // ****************************************
  logic              clk_sys = 1'b0, arst_n = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0, reg_rdata, exp_defl, e;
  logic              reg_wr = 1'b0, reg_rd = 1'b0, searches_done = 1'b0;
  logic [ADDR_W-1:0] first_data_addr = 12'h000, mem_addr;
  logic              mode_graphic = 1'b0, mode_char = 1'b0, mode_protected = 1'b0;
  logic              deflection_interlock = 1'b0, pen_hit_latch = 1'b0, busy_q = 1'b0;
  logic [3:0]        keys = 4'h0;
  logic [KEY_W-1:0]  key_char = 6'h00;
  logic              mem_rd, mem_wr, exam, cyc, start_marker_found;
  logic              deflection_transfer_pulse, char_strobe, char_cursor, char_new_line;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  logic [15:0]       defl_x, defl_y;
  logic [CODE_W-1:0] char_code;
  logic [WORD_W-1:0] mdl [0:(1<<ADDR_W)-1];
  logic [31:0]       exp_char [$];
  int                errors = 0, checks = 0, hold = 0, defl_seen = 0;

  always #12.5 clk_sys = ~clk_sys;

  display_regen_cursor_control i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .searches_done(searches_done),
    .first_data_addr(first_data_addr), .mode_graphic(mode_graphic), .mode_char(mode_char),
    .mode_protected(mode_protected), .deflection_interlock(deflection_interlock),
    .pen_hit_latch(pen_hit_latch), .key_advance(keys[0]), .key_backspace(keys[1]),
    .key_jump(keys[2]), .key_char_strobe(keys[3]), .key_char(key_char),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .byte_examine_pulse(exam), .buffer_cycle_start_pulse(cyc),
    .start_marker_found(start_marker_found),
    .deflection_transfer_pulse(deflection_transfer_pulse), .defl_x(defl_x),
    .defl_y(defl_y), .char_strobe(char_strobe), .char_code(char_code),
    .char_cursor(char_cursor), .char_new_line(char_new_line)
  );

  regen_buffer_model i_mem (
    .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic results();
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: buffer word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_disp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: display %h expected %h", $time, got, exp);
    end
  endtask

  // strobes are registered, so the value read at an edge belongs to the
  // cycle before; busy_q is the interlock level the block saw one edge earlier
  always @(posedge clk_sys) begin
    if ((char_strobe | deflection_transfer_pulse) === 1'b1) begin
      cmp_disp({31'h0, busy_q}, 32'h0);
    end
    if (char_strobe === 1'b1) begin
      e = (exp_char.size() > 0) ? exp_char.pop_front() : 32'hffff_ffff;
      cmp_disp({22'h0, char_cursor, char_new_line, char_code}, e);
    end
    if (deflection_transfer_pulse === 1'b1) begin
      cmp_disp({defl_x, defl_y}, exp_defl);
      defl_seen++;
    end
    busy_q = deflection_interlock | pen_hit_latch;
    if (hold > 0) begin
      hold--;
      if (hold == 0) begin
        {deflection_interlock, pen_hit_latch} <= 2'b00;
      end
    end
  end

  // ****************************************
  // stimulus helpers
  // ****************************************
  function automatic logic [WORD_W-1:0] mkw(input logic [7:0] c, input logic cur);
    return {~^{cur, c}, cur, c};
  endfunction

  // four data bytes, new line code in the last character, marker at even address
  task automatic load(input logic [ADDR_W-1:0] a, input int cur, input logic g);
    logic [7:0] c;
    for (int i = 0; i < 5; i++) begin
      c = g ? {1'b1, 7'($urandom)} : 8'h41 + 8'($urandom % 26);
      c = (i == 4) ? START_MARKER_CODE : (i == 3 && !g) ? NEW_LINE_CODE : c;
      mdl[a + i] = mkw(c, i == cur);
      i_mem.words[a + i] = mdl[a + i];
    end
  endtask

  task automatic push(input logic [ADDR_W-1:0] a);
    for (int i = 0; i < 4; i++) begin
      exp_char.push_back({22'h0, mdl[a+i][8], mdl[a+i][7:0] == NEW_LINE_CODE, mdl[a+i][7:0]});
    end
  endtask

  task automatic chk(input logic [ADDR_W-1:0] a);
    for (int i = 0; i < 5; i++) begin
      cmp_word(i_mem.words[a + i], mdl[a + i]);
    end
  endtask

  task automatic press(input logic [3:0] k, input logic [KEY_W-1:0] ch);
    @(posedge clk_sys);
    keys <= k;
    key_char <= ch;
    @(posedge clk_sys);
    keys <= 4'h0;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp_reg(reg_rdata, exp);
  endtask

  // one regeneration pass from the first data byte up to the start marker
  task automatic run(input logic [ADDR_W-1:0] a, input logic g, input logic p);
    int n;
    @(posedge clk_sys);
    searches_done <= 1'b1;
    first_data_addr <= a;
    mode_graphic <= g;
    mode_char <= ~g;
    mode_protected <= p;
    @(posedge clk_sys);
    searches_done <= 1'b0;
    n = 0;
    while (start_marker_found !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      results();
    end
    cmp_disp(32'(exp_char.size()), 32'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(12816));
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    reg_check(8'h00, 32'h7);
    reg_write(8'h0c, 32'hffff_ffff);
    reg_check(8'h0c, 32'h0);
    load(12'h100, 9, 1'b1);
    exp_defl = {mdl[12'h100][7:0], mdl[12'h101][7:0], mdl[12'h102][7:0], mdl[12'h103][7:0]};
    pen_hit_latch <= 1'b1;
    hold = 40;
    run(12'h100, 1'b1, 1'b0);
    cmp_disp(32'(defl_seen), 32'h1);
    reg_check(REG_ADDRESS, 32'h105);
    load(12'h200, 1, 1'b0);
    push(12'h200);
    deflection_interlock <= 1'b1;
    hold = 20;
    run(12'h200, 1'b0, 1'b0);
    chk(12'h200);
    load(12'h300, 1, 1'b0);
    press(4'h1, 6'h00);
    mdl[12'h301] ^= 10'h300;
    mdl[12'h302] ^= 10'h300;
    push(12'h300);
    run(12'h300, 1'b0, 1'b0);
    chk(12'h300);
    load(12'h400, 2, 1'b0);
    press(4'h2, 6'h00);
    mdl[12'h402] ^= 10'h300;
    push(12'h400);
    mdl[12'h401] ^= 10'h300;
    run(12'h400, 1'b0, 1'b0);
    chk(12'h400);
    load(12'h500, 1, 1'b0);
    key_char <= 6'($urandom);
    @(posedge clk_sys);
    press(4'h8, key_char);
    mdl[12'h501] = mkw({2'b00, key_char}, 1'b0);
    mdl[12'h502] ^= 10'h300;
    push(12'h500);
    run(12'h500, 1'b0, 1'b0);
    chk(12'h500);
    load(12'h600, 1, 1'b0);
    press(4'h8, 6'h21);
    push(12'h600);
    run(12'h600, 1'b0, 1'b1);
    chk(12'h600);
    load(12'h700, 1, 1'b0);
    load(12'h800, 9, 1'b0);
    press(4'h4, 6'h00);
    mdl[12'h701] ^= 10'h300;
    push(12'h700);
    run(12'h700, 1'b0, 1'b0);
    chk(12'h700);
    mdl[12'h800] ^= 10'h300;
    push(12'h800);
    run(12'h800, 1'b0, 1'b0);
    chk(12'h800);
    reg_write(8'h00, 32'h5);
    reg_check(8'h00, 32'h5);
    load(12'h900, 1, 1'b0);
    press(4'h1, 6'h00);
    push(12'h900);
    run(12'h900, 1'b0, 1'b0);
    chk(12'h900);
    reg_check(REG_STATUS, 32'h200);
    results();
  end
endmodule
